// >>> hdl/mbxcfg_top.sv
// Mailbox mode configuration: command frames, Normal/Legacy mailbox map,
// quick-read refresh and the host interrupt.
// Assumes the slave port delivers byte writes/reads on ref_clk_i and a
// busy level from a foreign clock; the frame-end strobe is local.
//
// What this block does
// - In boot ROM, frame 29 00 FF FF FF FF reboots into flash.
// - Answers application identifier 0x18, always available, no status registers.
// - After reset the mailboxes run in Normal mode.
// - Host writes command, waits; completion shows by flag and optional interrupt.
// - Normal mode supports streaming reads beyond 32 bytes.
// - Bit 7 enables interrupt after each command completes, or at each frame end when bit 5 is set.
// - Legacy mode: slots 20 to 31 become quick-read, lower stay command.
// - Quick-read slots refresh at the end of each sample frame.
// - Quick-read slots read directly without command or waiting.
// - Default slots: status, queue, FIFO, frame counter, X, Y, Z data.
// - Writing 0x10 sets the legacy bit and selects Legacy mode.
// - Config register at offset 0x00, read/write, resets 0x00, count 0x01.
// - Quick-read content comes from the separate content application.
// - Bit 6 sets interrupt polarity: 0 active high, 1 active low.
// - Update policy: always, idle with deferral, or after current transaction.
`timescale 1ns/100ps
module mbxcfg_top
    import mbxcfg_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  clk_en_i,
    input  wire logic                  boot_rom_active_i,
    input  wire logic                  wr_en_i,
    input  wire logic [MBX_AW-1:0]     wr_slot_i,
    input  wire logic [7:0]            wr_data_i,
    input  wire logic                  rd_en_i,
    input  wire logic [MBX_AW-1:0]     rd_slot_i,
    input  wire logic                  rd_stream_i,
    input  wire logic                  port_busy_i,
    input  wire logic                  frame_end_i,
    input  wire logic [QR_COUNT*8-1:0] qr_data_i,
    output logic      [7:0]            rd_data_o,
    output logic                       rd_valid_o,
    output logic                       command_complete_flag_o,
    output logic                       host_irq_o,
    output logic      [7:0]            mailbox_mode_config_o,
    output logic                       reboot_to_rom_o,
    output logic                       reboot_to_flash_o
);

    mbxcfg_state_t      state;
    logic [7:0]         mbx [MBX_COUNT];
    logic [7:0]         mailbox_mode_config;
    logic [3:0]         proc_cnt;
    logic               busy_meta;
    logic               busy_sync;
    logic               busy_q;
    logic               upd_pending;
    logic               qr_load;
    logic [7:0]         qr_rd;
    logic [MBX_AW-1:0]  stream_ptr;
    logic               legacy;
    logic               frame_sel;
    logic               cmd_start;
    logic               irq_event;
    logic               irq_level;
    logic               is_cfg_write;
    logic               is_cfg_read;
    logic               is_rom_req;
    logic               is_flash_req;
    logic [MBX_AW-1:0]  eff_rd_slot;

    // Slot lies in the quick-read window
    function automatic logic in_qr(input logic [MBX_AW-1:0] s);
        return (s >= QR_FIRST_SLOT) && (s <= QR_LAST_SLOT);
    endfunction

    assign legacy    = mailbox_mode_config[CFG_LEGACY];
    assign frame_sel = mailbox_mode_config[CFG_FRAME_EN];

    // ------------------------------------------------------------
    // Port busy synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_meta <= 1'b0;
            busy_sync <= 1'b0;
            busy_q    <= 1'b0;
        end else if (clk_en_i) begin
            busy_meta <= port_busy_i;
            busy_sync <= busy_meta;
            busy_q    <= busy_sync;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Writing slot 0 launches the frame already loaded in slots 1..5, so the
    // host loads trailing bytes first or writes slot 0 last in a burst.
    assign cmd_start = wr_en_i && (wr_slot_i == '0) && (state != MBXCFG_BUSY)
                       && !(legacy && in_qr(wr_slot_i));

    assign is_cfg_write = (mbx[0] == APPLICATION_IDENTIFIER_MBXCFG) && (mbx[1] == CMD_CONFIG_WRITE)
                          && (mbx[2] == CFG_OFFSET) && (mbx[3] == CFG_BYTE_COUNT);
    assign is_cfg_read  = (mbx[0] == APPLICATION_IDENTIFIER_MBXCFG) && (mbx[1] == CMD_CONFIG_READ)
                          && (mbx[2] == CFG_OFFSET) && (mbx[3] == CFG_BYTE_COUNT);
    assign is_rom_req   = !boot_rom_active_i && (mbx[0] == APPLICATION_IDENTIFIER_RSC)
                          && (mbx[1] == CMD_CONFIG_WRITE) && (mbx[2] == RSC_OFFSET)
                          && (mbx[3] == CFG_BYTE_COUNT) && (mbx[4] == RSC_ROM_BIT);
    assign is_flash_req = boot_rom_active_i && (mbx[0] == BOOT_TO_FLASH)
                          && (mbx[1] == BOOT_RESERVED) && (mbx[2] == BOOT_KEY)
                          && (mbx[3] == BOOT_KEY) && (mbx[4] == BOOT_KEY)
                          && (mbx[5] == BOOT_KEY);

    // ------------------------------------------------------------
    // Mailbox storage
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < MBX_COUNT; i++) begin
                mbx[i] <= 8'h00;
            end
        end else if (clk_en_i) begin
            if (state == MBXCFG_BUSY && proc_cnt == 4'h1 && is_cfg_read) begin
                mbx[4] <= mailbox_mode_config;
            end else if (wr_en_i && state != MBXCFG_BUSY
                         && !(legacy && in_qr(wr_slot_i))) begin
                mbx[wr_slot_i] <= wr_data_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Command processing state machine
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state    <= MBXCFG_IDLE;
            proc_cnt <= 4'h0;
        end else if (clk_en_i) begin
            case (state)
                MBXCFG_IDLE, MBXCFG_DONE: begin
                    if (cmd_start) begin
                        state    <= MBXCFG_BUSY;
                        proc_cnt <= PROC_CYCLES_W;
                    end
                end
                MBXCFG_BUSY: begin
                    if (proc_cnt == 4'h1) begin
                        state <= MBXCFG_DONE;
                    end
                    proc_cnt <= proc_cnt - 4'h1;
                end
                default: begin
                    state <= MBXCFG_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Configuration register and reboot requests
    // ------------------------------------------------------------
    // Only the command frame can change the register; a lone slot write cannot.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mailbox_mode_config <= CFG_RESET;
        end else if (clk_en_i) begin
            if (state == MBXCFG_BUSY && proc_cnt == 4'h1 && is_cfg_write) begin
                mailbox_mode_config <= mbx[4] & CFG_WRITE_MASK;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reboot_to_rom_o   <= 1'b0;
            reboot_to_flash_o <= 1'b0;
        end else if (clk_en_i) begin
            reboot_to_rom_o   <= (state == MBXCFG_BUSY) && (proc_cnt == 4'h1)
                                 && is_rom_req;
            reboot_to_flash_o <= (state == MBXCFG_BUSY) && (proc_cnt == 4'h1)
                                 && is_flash_req;
        end
    end

    // ------------------------------------------------------------
    // Command complete flag
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            command_complete_flag_o <= 1'b0;
        end else if (clk_en_i) begin
            if (state == MBXCFG_BUSY && proc_cnt == 4'h1) begin
                command_complete_flag_o <= 1'b1;
            end else if (cmd_start) begin
                command_complete_flag_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Quick-read refresh policy
    // ------------------------------------------------------------
    // Mode 1 and mode 2 both hold a frame across a busy port; mode 2 fires on
    // the falling edge of busy, mode 1 on any idle cycle, which coincide here.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            upd_pending <= 1'b0;
            qr_load     <= 1'b0;
        end else if (clk_en_i) begin
            qr_load <= 1'b0;
            if (legacy) begin
                case (mailbox_mode_config[CFG_UPD_HI:CFG_UPD_LO])
                    UPD_IDLE_WAIT: begin
                        if ((frame_end_i || upd_pending) && !busy_sync) begin
                            qr_load     <= 1'b1;
                            upd_pending <= 1'b0;
                        end else if (frame_end_i) begin
                            upd_pending <= 1'b1;
                        end
                    end
                    UPD_AFTER_XFER: begin
                        if (frame_end_i && !busy_sync) begin
                            qr_load <= 1'b1;
                        end else if (frame_end_i) begin
                            upd_pending <= 1'b1;
                        end else if (upd_pending && busy_q && !busy_sync) begin
                            qr_load     <= 1'b1;
                            upd_pending <= 1'b0;
                        end
                    end
                    default: begin
                        qr_load     <= frame_end_i;
                        upd_pending <= 1'b0;
                    end
                endcase
            end else begin
                upd_pending <= 1'b0;
            end
        end
    end

    // Slot order (status, queue, FIFO, counter, X, Y, Z) is set by the selector
    mbxcfg_qr_bank u_qr_bank (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .clk_en_i  (clk_en_i),
        .load_i    (qr_load),
        .data_i    (qr_data_i),
        .rd_idx_i  (4'(eff_rd_slot - QR_FIRST_SLOT)),
        .rd_data_o (qr_rd)
    );

    // ------------------------------------------------------------
    // Read path with streaming
    // ------------------------------------------------------------
    // A streaming read walks the response slots and wraps, so responses past
    // 32 bytes are read without a fresh address phase.
    assign eff_rd_slot = rd_stream_i ? stream_ptr : rd_slot_i;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stream_ptr <= '0;
        end else if (clk_en_i && rd_en_i) begin
            stream_ptr <= eff_rd_slot + 5'h01;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else if (clk_en_i) begin
            rd_valid_o <= rd_en_i;
            if (rd_en_i) begin
                if (legacy && in_qr(eff_rd_slot)) begin
                    rd_data_o <= qr_rd;
                end else begin
                    rd_data_o <= mbx[eff_rd_slot];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Host interrupt
    // ------------------------------------------------------------
    assign irq_event = frame_sel ? frame_end_i
                                 : (state == MBXCFG_BUSY && proc_cnt == 4'h1);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_level <= 1'b0;
        end else if (clk_en_i) begin
            if (!mailbox_mode_config[CFG_IRQ_EN]) begin
                irq_level <= 1'b0;
            end else if (irq_event) begin
                irq_level <= 1'b1;
            end else if (cmd_start) begin
                irq_level <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            host_irq_o            <= 1'b0;
            mailbox_mode_config_o <= CFG_RESET;
        end else if (clk_en_i) begin
            host_irq_o            <= irq_level ^ mailbox_mode_config[CFG_IRQ_POL];
            mailbox_mode_config_o <= mailbox_mode_config;
        end
    end

endmodule

// >>> hdl/mbxcfg_pkg.sv
// Constants for the mailbox mode configuration block.
// Assumes a byte-wide mailbox write/read port clocked by ref_clk_i.
package mbxcfg_pkg;

    // ------------------------------------------------------------
    // Mailbox layout
    // ------------------------------------------------------------
    localparam int          MBX_COUNT        = 32;
    localparam int          MBX_AW           = 5;
    localparam logic [4:0]  QR_FIRST_SLOT    = 5'h14;
    localparam logic [4:0]  QR_LAST_SLOT     = 5'h1f;
    localparam int          QR_COUNT         = 12;
    localparam int          STREAM_CHUNK     = 32;

    // ------------------------------------------------------------
    // Frame codes
    // ------------------------------------------------------------
    localparam logic [7:0]  APPLICATION_IDENTIFIER_MBXCFG    = 8'h18;
    localparam logic [7:0]  APPLICATION_IDENTIFIER_RSC       = 8'h17;
    localparam logic [7:0]  CMD_CONFIG_WRITE = 8'h20;
    localparam logic [7:0]  CMD_CONFIG_READ  = 8'h10;
    localparam logic [7:0]  BOOT_TO_FLASH    = 8'h29;
    localparam logic [7:0]  BOOT_RESERVED    = 8'h00;
    localparam logic [7:0]  BOOT_KEY         = 8'hff;
    localparam logic [7:0]  RSC_OFFSET       = 8'h01;
    localparam logic [7:0]  RSC_ROM_BIT      = 8'h80;
    localparam logic [7:0]  CFG_BYTE_COUNT   = 8'h01;

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    localparam logic [7:0]  CFG_OFFSET       = 8'h00;
    localparam logic [7:0]  CFG_RESET        = 8'h00;
    localparam logic [7:0]  CFG_WRITE_MASK   = 8'hfc;
    localparam int          CFG_IRQ_EN       = 7;
    localparam int          CFG_IRQ_POL      = 6;
    localparam int          CFG_FRAME_EN     = 5;
    localparam int          CFG_LEGACY       = 4;
    localparam int          CFG_UPD_HI       = 3;
    localparam int          CFG_UPD_LO       = 2;

    localparam logic [1:0]  UPD_ALWAYS       = 2'h0;
    localparam logic [1:0]  UPD_IDLE_WAIT    = 2'h1;
    localparam logic [1:0]  UPD_AFTER_XFER   = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          PROC_TIME_NS     = 50;
    localparam int          CLK_PERIOD_NS    = 5;
    localparam int          PROC_CYCLES      = (PROC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  PROC_CYCLES_W    = 4'(PROC_CYCLES);

    typedef enum logic [1:0] {
        MBXCFG_IDLE,
        MBXCFG_BUSY,
        MBXCFG_DONE
    } mbxcfg_state_t;

endpackage

// >>> hdl/mbxcfg_qr_bank.sv
// Quick-read slot bank: twelve bytes refreshed at frame end.
// Assumes frame data arrives from the content selector on the same clock.
`timescale 1ns/100ps
module mbxcfg_qr_bank
    import mbxcfg_pkg::*;
(
    input  wire logic                 ref_clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 clk_en_i,
    input  wire logic                 load_i,
    input  wire logic [QR_COUNT*8-1:0] data_i,
    input  wire logic [3:0]           rd_idx_i,
    output logic      [7:0]           rd_data_o
);

    logic [7:0] slot [QR_COUNT];

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < QR_COUNT; g++) begin : g_slot
            always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    slot[g] <= 8'h00;
                end else if (clk_en_i && load_i) begin
                    slot[g] <= data_i[g*8 +: 8];
                end
            end
        end
    endgenerate

    always_comb begin
        rd_data_o = (rd_idx_i < 4'(QR_COUNT)) ? slot[rd_idx_i] : 8'h00;
    end

endmodule

// >>> bench/mbxcfg_monitor.sv
// Assertion checker for the mailbox mode configuration top.
// Assumes it is bound to mbxcfg_top and sees only its ports.
`timescale 1ns/100ps
module mbxcfg_monitor
    import mbxcfg_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       clk_en_i,
    input  wire logic       boot_rom_active_i,
    input  wire logic       wr_en_i,
    input  wire logic [4:0] wr_slot_i,
    input  wire logic       rd_en_i,
    input  wire logic       rd_valid_o,
    input  wire logic       command_complete_flag_o,
    input  wire logic       host_irq_o,
    input  wire logic [7:0] mailbox_mode_config_o,
    input  wire logic       reboot_to_rom_o,
    input  wire logic       reboot_to_flash_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    read_answer_a: assert property (clk_en_i && rd_en_i |=> rd_valid_o)
        else $error("read not answered one cycle later");
    no_stray_valid_a: assert property (clk_en_i && !rd_en_i |=> !rd_valid_o)
        else $error("read valid without a read");
    flag_clear_a: assert property (clk_en_i && wr_en_i && wr_slot_i == 5'h00
        && command_complete_flag_o |=> !command_complete_flag_o)
        else $error("complete flag not cleared by new command");
    flag_latency_a: assert property ($fell(command_complete_flag_o)
        |-> ##[9:11] command_complete_flag_o)
        else $error("complete flag not set after processing time");
    irq_level_a: assert property ($rose(command_complete_flag_o)
        && mailbox_mode_config_o[CFG_IRQ_EN] && !mailbox_mode_config_o[CFG_FRAME_EN]
        |=> host_irq_o == !mailbox_mode_config_o[CFG_IRQ_POL])
        else $error("interrupt level wrong after completion");
    irq_quiet_a: assert property (mailbox_mode_config_o == 8'h00
        && $past(mailbox_mode_config_o) == 8'h00 |-> !host_irq_o)
        else $error("interrupt active while disabled");
    cfg_low_bits_a: assert property (mailbox_mode_config_o[1:0] == 2'h0)
        else $error("reserved config bits not zero");
    cfg_change_a: assert property ($changed(mailbox_mode_config_o)
        |-> $past(command_complete_flag_o) && !$past(command_complete_flag_o, 2))
        else $error("config changed outside command completion");
    rom_reboot_a: assert property (reboot_to_rom_o
        |-> $rose(command_complete_flag_o) && !boot_rom_active_i)
        else $error("reboot to boot ROM at wrong time");
    flash_reboot_a: assert property (reboot_to_flash_o
        |-> $rose(command_complete_flag_o) && boot_rom_active_i)
        else $error("reboot to flash at wrong time");

    cover property ($rose(command_complete_flag_o));
    cover property ($rose(mailbox_mode_config_o[CFG_LEGACY]));
    cover property (reboot_to_flash_o);
endmodule

bind mbxcfg_top mbxcfg_monitor mon (.ref_clk_i, .arst_n_i, .clk_en_i, .boot_rom_active_i,
    .wr_en_i, .wr_slot_i, .rd_en_i, .rd_valid_o, .command_complete_flag_o, .host_irq_o,
    .mailbox_mode_config_o, .reboot_to_rom_o, .reboot_to_flash_o);

// >>> bench/mbxcfg_host_model.sv
// Host side of the mailbox port: byte writes, command frames, reads.
// Assumes one clock shared with the block; signals change after edges.
`timescale 1ns/100ps
module mbxcfg_host_model
    import mbxcfg_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       flag_i,
    input  wire logic       rd_valid_i,
    input  wire logic [7:0] rd_data_i,
    output logic            wr_en_o,
    output logic      [4:0] wr_slot_o,
    output logic      [7:0] wr_data_o,
    output logic            rd_en_o,
    output logic      [4:0] rd_slot_o,
    output logic            rd_stream_o
);
    initial begin
        {wr_en_o, wr_slot_o, wr_data_o, rd_en_o, rd_slot_o, rd_stream_o} = '0;
    end
    task automatic wr_byte(input logic [4:0] s, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr_en_o   <= 1'b1;
        wr_slot_o <= s;
        wr_data_o <= d;
        @(posedge ref_clk_i);
        wr_en_o   <= 1'b0;
        wr_slot_o <= ~s; // Released lines toggle so stale values never look valid
        wr_data_o <= ~d;
    endtask
    // Slot 0 goes last since it starts processing, then poll the flag
    task automatic send_cmd(input logic [7:0] f [6], input int n, output bit ok);
        int i;
        for (i = 1; i < n; i++) begin
            wr_byte(5'(i), f[i]);
        end
        wr_byte(5'h00, f[0]);
        ok = 1'b0;
        for (i = 0; i < 40 && !ok; i++) begin
            @(posedge ref_clk_i);
            ok = (flag_i === 1'b1);
        end
    endtask
    task automatic read_byte(input logic [4:0] s, input logic st, output logic [7:0] d,
                             output bit ok);
        @(posedge ref_clk_i);
        rd_en_o     <= 1'b1;
        rd_slot_o   <= s;
        rd_stream_o <= st;
        @(posedge ref_clk_i);
        rd_en_o   <= 1'b0;
        rd_slot_o <= ~s;
        @(posedge ref_clk_i);
        ok = (rd_valid_i === 1'b1);
        d  = rd_data_i;
    endtask
endmodule

// >>> bench/mailbox_mode_config_tb.sv
// Self-checking bench for the mailbox mode configuration top.
// Assumes the host model drives the port; clk_en_i is held high.
`timescale 1ns/100ps
module mailbox_mode_config_tb;
    import mbxcfg_pkg::*;
    logic                  ref_clk_i = 1'b0;
    logic                  arst_n_i  = 1'b0;
    logic                  boot_rom  = 1'b0;
    logic                  busy      = 1'b0;
    logic                  fend      = 1'b0;
    logic [QR_COUNT*8-1:0] qr        = '0;
    logic                  wr_en, rd_en, rd_st, rd_valid, flag, irq, to_rom, to_flash;
    logic [4:0]            wr_slot, rd_slot;
    logic [7:0]            wr_data, rd_data, cfg, d;
    logic                  rom_seen  = 1'b0;
    logic                  fl_seen   = 1'b0;
    int                    error_cnt = 0;
    int                    num_checks = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (to_rom === 1'b1) rom_seen <= 1'b1;
        if (to_flash === 1'b1) fl_seen <= 1'b1;
    end

    mbxcfg_top uut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
        .boot_rom_active_i(boot_rom), .wr_en_i(wr_en), .wr_slot_i(wr_slot),
        .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_slot_i(rd_slot), .rd_stream_i(rd_st),
        .port_busy_i(busy), .frame_end_i(fend), .qr_data_i(qr), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .command_complete_flag_o(flag), .host_irq_o(irq),
        .mailbox_mode_config_o(cfg), .reboot_to_rom_o(to_rom), .reboot_to_flash_o(to_flash));
    mbxcfg_host_model host (.ref_clk_i(ref_clk_i), .flag_i(flag), .rd_valid_i(rd_valid),
        .rd_data_i(rd_data), .wr_en_o(wr_en), .wr_slot_o(wr_slot), .wr_data_o(wr_data),
        .rd_en_o(rd_en), .rd_slot_o(rd_slot), .rd_stream_o(rd_st));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input logic [7:0] a, b, c, e, g, h, input int n);
        logic [7:0] f [6];
        bit         ok;
        f = '{a, b, c, e, g, h};
        host.send_cmd(f, n, ok);
        if (!ok) begin
            error_cnt++;
            final_report;
        end
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic rd(input logic [4:0] s, input logic st);
        bit ok;
        host.read_byte(s, st, d, ok);
        chk8("rd_valid", 8'h01, {7'h00, ok});
    endtask
    task automatic frame(input logic [7:0] base);
        int k;
        @(posedge ref_clk_i);
        for (k = 0; k < QR_COUNT; k++) qr[k*8 +: 8] <= base + 8'(k);
        fend <= 1'b1;
        @(posedge ref_clk_i);
        fend <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk8("cfg", 8'h00, cfg);
        chk8("flag", 8'h00, {7'h00, flag});
        chk8("irq", 8'h00, {7'h00, irq});
    endtask
    task automatic t_irq;
        run(8'h18, 8'h20, 8'h00, 8'h01, 8'h80, 8'h00, 5);
        chk8("cfg", 8'h80, cfg);
        chk8("irq", 8'h00, {7'h00, irq});
        run(8'h18, 8'h10, 8'h00, 8'h01, 8'h00, 8'h00, 4);
        chk8("irq", 8'h01, {7'h00, irq});
        run(8'h18, 8'h20, 8'h00, 8'h01, 8'hc0, 8'h00, 5);
        chk8("cfg", 8'hc0, cfg);
        chk8("irq", 8'h00, {7'h00, irq});
    endtask
    task automatic t_reg;
        run(8'h18, 8'h10, 8'h00, 8'h01, 8'h00, 8'h00, 4);
        rd(5'h04, 1'b0);
        chk8("cfg readback", 8'hc0, d);
        run(8'h18, 8'h20, 8'h00, 8'h01, 8'hff, 8'h00, 5);
        chk8("cfg", 8'hfc, cfg);
        run(8'h18, 8'h20, 8'h05, 8'h01, 8'h00, 8'h00, 5);
        chk8("cfg bad offset", 8'hfc, cfg);
        run(8'h18, 8'h20, 8'h00, 8'h02, 8'h00, 8'h00, 5);
        chk8("cfg bad count", 8'hfc, cfg);
        chk8("irq idle", 8'h01, {7'h00, irq});
        frame(8'h00);
        repeat (2) @(posedge ref_clk_i);
        chk8("frame irq", 8'h00, {7'h00, irq});
    endtask
    task automatic t_stream;
        int i;
        for (i = 0; i < 4; i++) host.wr_byte(5'(8 + i), 8'h30 + 8'(i));
        rd(5'h08, 1'b0);
        for (i = 1; i < 4; i++) begin
            rd(5'h00, 1'b1);
            chk8("stream byte", 8'h30 + 8'(i), d);
        end
    endtask
    task automatic t_reboot;
        run(8'h17, 8'h20, 8'h01, 8'h01, 8'h80, 8'h00, 5);
        chk8("to rom", 8'h01, {7'h00, rom_seen});
        @(posedge ref_clk_i) boot_rom <= 1'b1;
        run(8'h29, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 6);
        chk8("to flash", 8'h01, {7'h00, fl_seen});
        @(posedge ref_clk_i) boot_rom <= 1'b0;
    endtask
    task automatic t_legacy;
        int k;
        run(8'h18, 8'h20, 8'h00, 8'h01, 8'h10, 8'h00, 5);
        chk8("cfg", 8'h10, cfg);
        frame(8'h40);
        repeat (3) @(posedge ref_clk_i);
        for (k = 0; k < QR_COUNT; k++) begin
            rd(QR_FIRST_SLOT + 5'(k), 1'b0);
            chk8("quick read", 8'h40 + 8'(k), d);
        end
        host.wr_byte(5'h15, 8'h00);
        rd(5'h15, 1'b0);
        chk8("quick read guarded", 8'h41, d);
        for (k = 1; k < 3; k++) begin
            run(8'h18, 8'h20, 8'h00, 8'h01, 8'h10 | 8'(k << 2), 8'h00, 5);
            @(posedge ref_clk_i) busy <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            frame(8'h40 + 8'(k * 32));
            repeat (6) @(posedge ref_clk_i);
            rd(QR_FIRST_SLOT, 1'b0);
            chk8("deferred", 8'h40 + 8'((k - 1) * 32), d);
            @(posedge ref_clk_i) busy <= 1'b0;
            repeat (6) @(posedge ref_clk_i);
            rd(QR_FIRST_SLOT, 1'b0);
            chk8("updated", 8'h40 + 8'(k * 32), d);
        end
    endtask

    initial begin
        repeat (8) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        t_reset;
        t_irq;
        t_reg;
        t_stream;
        t_reboot;
        t_legacy;
        final_report;
    end
endmodule
